// [src/sensor_consts.svh]
/*
  Shared constants for the sensor reset/boot link: timing figures,
  two-wire register addresses and field positions.
  Assumes a 25 MHz system clock on both ends.
*/
`ifndef SENSOR_CONSTS_SVH
`define SENSOR_CONSTS_SVH
// System clock period, ns
`define CLK_PERIOD_NS 40
// Internal boot time, ms
`define BOOT_TIME_MS 44.5
// Boot time in clock cycles
`define BOOT_CYCLES (int'(`BOOT_TIME_MS * 1000000.0 / `CLK_PERIOD_NS))
// Least reset pulse, reference-clock cycles
`define RST_MIN_REF 50
// Reference clock guard around reset edges, reference cycles
`define REF_GUARD 10
// System clocks per reference-clock cycle
`define REF_DIV 2
// Internal power-on reset length, clocks
`define POR_CYCLES 24'h000010
// Clocks without a reference edge before the clock counts as stopped
`define REF_IDLE_LIMIT 4'hF
// Host wait for an answer before giving up, clocks
`define BUS_TIMEOUT 24'h000040
// Host gap between two status polls, clocks
`define POLL_GAP 24'h000100
// Register addresses
`define SYS_CONTROL_ADDR 16'h001A
`define CMD_ADDR 16'h0080
`define STATE_ADDR 16'h0082
// Field positions
`define SOFT_RST_BIT 0
`define BOOT_BUSY_BIT 1
`define STANDBY_BIT 0
// Data value during blanking
`define BLANK_DATA 8'h00
`endif

// [src/sensor_device.sv]
/*
  Sensor end: power-on, hard and soft reset, boot timer, standby and
  streaming, register answers and frame timing on the parallel port.
  Assumes the host keeps the reset and reference clock rules.
*/
`timescale 1ns/1ps
`include "sensor_consts.svh"
module sensor_device #(
  parameter int BOOT_CYCLES = `BOOT_CYCLES,
  parameter int ACTIVE_COLS = 16,
  parameter int ACTIVE_ROWS = 8,
  parameter int HBLANK = 8,
  parameter int VBLANK = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Board link
  sensor_link_if.device link,
  // Supply and straps
  input wire logic power_good,
  input wire logic boot_select,
  input wire logic par_enable_n,
  // Status
  output logic in_reset,
  output logic booting,
  output logic streaming
);
  // Frame totals
  localparam logic [11:0] COL_LAST = 12'(ACTIVE_COLS + HBLANK - 1);
  localparam logic [11:0] ROW_LAST = 12'(ACTIVE_ROWS + VBLANK - 1);
  localparam logic [23:0] BOOT_LAST = 24'(BOOT_CYCLES - 1);

  sensor_pkg::dev_regs_type r_reg; // Current state
  sensor_pkg::dev_regs_type r_next; // Next state
  logic ref_alive; // Reference clock seen lately
  logic serve; // Bus request answered this cycle
  logic active; // Next pixel lies in the valid image

  // Counter step with wrap
  function automatic logic [11:0] wrap_inc(input logic [11:0] v, input logic [11:0] last);
    wrap_inc = (v == last) ? 12'h000 : 12'(v + 12'h001);
  endfunction

  // Register readback
  function automatic logic [15:0] reg_read(input logic [15:0] addr,
                                           input sensor_pkg::dev_regs_type s);
    reg_read = 16'h0000;
    if (addr == `SYS_CONTROL_ADDR) begin
      reg_read[`SOFT_RST_BIT] = s.soft_rst;
    end else if (addr == `CMD_ADDR) begin
      reg_read[`BOOT_BUSY_BIT] = (s.state != sensor_pkg::DEV_STANDBY) &&
                                 (s.state != sensor_pkg::DEV_STREAM);
    end else if (addr == `STATE_ADDR) begin
      reg_read[`STANDBY_BIT] = s.standby_req;
    end
  endfunction

  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.bus_ack = 1'b0;
    r_next.bus_nak = 1'b0;
    r_next.bus_oe = 1'b0;
    // Reference clock activity watch
    r_next.ref_prev = link.input_ref_clock;
    if (link.input_ref_clock != r_reg.ref_prev) begin
      r_next.ref_idle = 4'h0;
    end else if (r_reg.ref_idle != `REF_IDLE_LIMIT) begin
      r_next.ref_idle = 4'(r_reg.ref_idle + 4'h1);
    end
    ref_alive = r_reg.ref_idle != `REF_IDLE_LIMIT;
    active = 1'b0;
    unique case (r_reg.state)
      sensor_pkg::DEV_OFF: begin
        // Supply up starts the on-chip reset
        if (power_good) begin
          r_next.state = sensor_pkg::DEV_POR;
          r_next.cnt = 24'h000000;
        end
      end
      sensor_pkg::DEV_POR: begin
        // Power-on reset timer, strap caught at its end
        r_next.cnt = 24'(r_reg.cnt + 24'h000001);
        if (r_reg.cnt == `POR_CYCLES) begin
          r_next.boot_sel = boot_select;
          r_next.state = sensor_pkg::DEV_RESET;
        end
      end
      sensor_pkg::DEV_RESET: begin
        // Leave reset once pin and soft bit are both released
        if (link.master_reset_n && !r_reg.soft_rst) begin
          r_next.state = sensor_pkg::DEV_BOOT;
          r_next.cnt = 24'h000000;
        end
      end
      sensor_pkg::DEV_BOOT: begin
        // Internal boot timer
        r_next.cnt = 24'(r_reg.cnt + 24'h000001);
        if (r_reg.cnt == BOOT_LAST) begin
          r_next.standby_req = !r_reg.boot_sel;
          r_next.state = r_reg.boot_sel ? sensor_pkg::DEV_STREAM :
                                          sensor_pkg::DEV_STANDBY;
        end
      end
      sensor_pkg::DEV_STANDBY: begin
        // Wait for the host to ask for streaming
        if (!r_reg.standby_req) begin
          r_next.state = sensor_pkg::DEV_STREAM;
        end
      end
      sensor_pkg::DEV_STREAM: begin
        // Raster walk over image and blanking
        r_next.col = wrap_inc(r_reg.col, COL_LAST);
        if (r_reg.col == COL_LAST) begin
          r_next.row = wrap_inc(r_reg.row, ROW_LAST);
        end
        active = (r_reg.row < 12'(ACTIVE_ROWS)) && (r_reg.col < 12'(ACTIVE_COLS));
        if (r_reg.standby_req) begin
          r_next.state = sensor_pkg::DEV_STANDBY;
        end
      end
    endcase
    // Parallel data: pixel inside the image, zero in blanking
    r_next.row_act = active;
    r_next.frame_act = (r_reg.state == sensor_pkg::DEV_STREAM) &&
                       (r_reg.row < 12'(ACTIVE_ROWS));
    r_next.pix = active ? 8'(r_reg.col + r_reg.row) : `BLANK_DATA;
    r_next.lsb = active ? r_reg.col[1:0] : 2'h0;
    r_next.pclk = (r_reg.state == sensor_pkg::DEV_STREAM) ? !r_reg.pclk : 1'b0;
    // Bus answers only with the pads out of reset and the clock running
    serve = link.bus_req && !r_reg.bus_ack && ref_alive && link.master_reset_n &&
            (r_reg.state != sensor_pkg::DEV_OFF) && (r_reg.state != sensor_pkg::DEV_POR);
    if (serve) begin
      r_next.bus_ack = 1'b1;
      r_next.bus_oe = 1'b1;
      if ((r_reg.state == sensor_pkg::DEV_BOOT) &&
          (link.bus_write || link.bus_addr != `CMD_ADDR)) begin
        r_next.bus_nak = 1'b1;
      end else if (link.bus_write) begin
        // Writes; unmapped addresses are acknowledged and dropped
        if (link.bus_addr == `SYS_CONTROL_ADDR) begin
          r_next.soft_rst = link.bus_wdata[`SOFT_RST_BIT];
        end else if (link.bus_addr == `STATE_ADDR &&
                     (r_reg.state == sensor_pkg::DEV_STANDBY ||
                      r_reg.state == sensor_pkg::DEV_STREAM)) begin
          r_next.standby_req = link.bus_wdata[`STANDBY_BIT];
        end
      end else begin
        r_next.bus_rdata = reg_read(link.bus_addr, r_reg);
      end
    end
    // Soft reset bit drives the same reset state as the pin
    if (r_reg.soft_rst && r_reg.state != sensor_pkg::DEV_OFF &&
        r_reg.state != sensor_pkg::DEV_POR) begin
      r_next.state = sensor_pkg::DEV_RESET;
    end
    // Pin low forces and holds reset, clearing the soft bit too
    if (!link.master_reset_n && r_reg.state != sensor_pkg::DEV_OFF &&
        r_reg.state != sensor_pkg::DEV_POR) begin
      r_next.state = sensor_pkg::DEV_RESET;
      r_next.soft_rst = 1'b0;
    end
    // Reset state clears mode and raster
    if (r_next.state == sensor_pkg::DEV_RESET) begin
      r_next.standby_req = 1'b0;
      r_next.col = 12'h000;
      r_next.row = 12'h000;
      r_next.cnt = 24'h000000;
    end
    // Drive parallel pins only while streaming or booting with enable low
    r_next.par_oe = !par_enable_n && (r_next.state == sensor_pkg::DEV_STREAM ||
                                      r_next.state == sensor_pkg::DEV_BOOT);
    // Supply loss drops everything
    if (!power_good) begin
      r_next = '0;
      r_next.state = sensor_pkg::DEV_OFF;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // Parallel port, cut at once by the pin or supply
  assign link.par_oe = r_reg.par_oe && link.master_reset_n && power_good;
  assign link.pixel_data_out = r_reg.pix;
  assign link.pixel_lsb_out = r_reg.lsb;
  assign link.pixel_clock_out = r_reg.pclk;
  assign link.row_active_out = r_reg.row_act;
  assign link.frame_active_out = r_reg.frame_act;
  // Lanes held low whenever powered, parallel mode only
  assign link.lane_out = 4'h0;
  assign link.lane_oe = power_good;
  // Bus answer
  assign link.bus_ack = r_reg.bus_ack;
  assign link.bus_nak = r_reg.bus_nak;
  assign link.bus_rdata = r_reg.bus_rdata;
  assign link.ctrl_bus_data_oe = r_reg.bus_oe;
  // Status
  assign in_reset = r_reg.state == sensor_pkg::DEV_RESET || r_reg.state == sensor_pkg::DEV_POR;
  assign booting = r_reg.state == sensor_pkg::DEV_BOOT;
  assign streaming = r_reg.state == sensor_pkg::DEV_STREAM;
endmodule

// [src/sensor_host.sv]
/*
  Host end: drives reset pin and reference clock, waits out boot,
  polls the command register, runs soft resets and user transfers,
  and captures pixels. Assumes the device answers one clock after.
*/
`timescale 1ns/1ps
`include "sensor_consts.svh"
module sensor_host #(
  parameter int BOOT_WAIT = `BOOT_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Board link
  sensor_link_if.host link,
  // Sequencing requests
  input wire logic hard_reset_req,
  input wire logic soft_reset_req,
  input wire logic ref_stop,
  // User register command
  input wire logic cmd_valid,
  input wire logic cmd_write,
  input wire logic [15:0] cmd_addr,
  input wire logic [15:0] cmd_wdata,
  output logic cmd_ready,
  // User register answer
  output logic rsp_valid,
  output logic rsp_error,
  output logic [15:0] rsp_rdata,
  // Status and captured pixels
  output logic device_ready,
  output logic pix_valid,
  output logic [9:0] pix_word
);
  localparam logic [23:0] HOLD_LAST = 24'(`RST_MIN_REF * `REF_DIV - 1);
  localparam logic [23:0] GUARD_LAST = 24'(`REF_GUARD * `REF_DIV - 1);
  localparam logic [23:0] BOOT_LAST = 24'(BOOT_WAIT - 1);

  sensor_pkg::host_regs_type r_reg; // Current state
  sensor_pkg::host_regs_type r_next; // Next state

  // Next-state logic
  always_comb begin
    r_next = r_reg;
    r_next.rsp_valid = 1'b0;
    r_next.cnt = 24'(r_reg.cnt + 24'h000001);
    // Reference clock parked by ref_stop while idle or on any bus transfer (user, poll or soft reset)
    // Hard reset sequence and boot/poll waits always run it
    r_next.ref_clk = (ref_stop && (r_reg.state == sensor_pkg::H_READY ||
                                   r_reg.state == sensor_pkg::H_BUS)) ?
                     r_reg.ref_clk : !r_reg.ref_clk;
    // Capture when the port is enabled and both valid flags are high
    r_next.pix_valid = link.par_oe && link.row_active_out && link.frame_active_out;
    if (r_next.pix_valid) begin
      r_next.pix_word = {link.pixel_data_out, link.pixel_lsb_out};
    end
    unique case (r_reg.state)
      sensor_pkg::H_WAIT: begin
        // Fixed wait, then a status poll
        if (r_reg.cnt == r_reg.wait_lim) begin
          r_next.state = sensor_pkg::H_BUS;
          r_next.kind = sensor_pkg::K_POLL;
          r_next.req = 1'b1;
          r_next.write = 1'b0;
          r_next.addr = `CMD_ADDR;
          r_next.cnt = 24'h000000;
        end
      end
      sensor_pkg::H_BUS: begin
        // One transfer; answer or timeout ends it
        if (link.bus_ack || r_reg.cnt == `BUS_TIMEOUT) begin
          r_next.req = 1'b0;
          r_next.cnt = 24'h000000;
          unique case (r_reg.kind)
            sensor_pkg::K_USER: begin
              r_next.rsp_valid = 1'b1;
              r_next.rsp_error = !link.bus_ack || link.bus_nak;
              r_next.rsp_rdata = link.bus_rdata;
              r_next.state = sensor_pkg::H_READY;
            end
            sensor_pkg::K_POLL: begin
              // Busy, refused or silent: try again later
              if (link.bus_ack && !link.bus_nak && !link.bus_rdata[`BOOT_BUSY_BIT]) begin
                r_next.ready = 1'b1;
                r_next.state = sensor_pkg::H_READY;
              end else begin
                r_next.wait_lim = `POLL_GAP;
                r_next.state = sensor_pkg::H_WAIT;
              end
            end
            sensor_pkg::K_SOFT_SET: begin
              // Set done, now clear the bit
              r_next.kind = sensor_pkg::K_SOFT_CLR;
              r_next.wdata = 16'h0000;
              r_next.req = 1'b1;
            end
            sensor_pkg::K_SOFT_CLR: begin
              r_next.wait_lim = BOOT_LAST;
              r_next.state = sensor_pkg::H_WAIT;
            end
          endcase
        end
      end
      sensor_pkg::H_READY: begin
        // Accept soft reset, hard reset or a user transfer
        r_next.cnt = 24'h000000;
        if (hard_reset_req) begin
          r_next.ready = 1'b0;
          r_next.state = sensor_pkg::H_PRE;
        end else if (soft_reset_req) begin
          r_next.ready = 1'b0;
          r_next.state = sensor_pkg::H_BUS;
          r_next.kind = sensor_pkg::K_SOFT_SET;
          r_next.req = 1'b1;
          r_next.write = 1'b1;
          r_next.addr = `SYS_CONTROL_ADDR;
          r_next.wdata = 16'h0001;
        end else if (cmd_valid) begin
          r_next.state = sensor_pkg::H_BUS;
          r_next.kind = sensor_pkg::K_USER;
          r_next.req = 1'b1;
          r_next.write = cmd_write;
          r_next.addr = cmd_addr;
          r_next.wdata = cmd_wdata;
        end
      end
      sensor_pkg::H_PRE: begin
        // Clock runs before the reset edge
        if (r_reg.cnt == GUARD_LAST) begin
          r_next.rst_n = 1'b0;
          r_next.cnt = 24'h000000;
          r_next.state = sensor_pkg::H_HARD;
        end
      end
      sensor_pkg::H_HARD: begin
        // Hold the pin low, clock running throughout
        if (r_reg.cnt == HOLD_LAST) begin
          r_next.rst_n = 1'b1;
          r_next.wait_lim = BOOT_LAST;
          r_next.cnt = 24'h000000;
          r_next.state = sensor_pkg::H_WAIT;
        end
      end
    endcase
  end

  // State register; power-up starts with the boot wait
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      r_reg <= '0;
      r_reg.state <= sensor_pkg::H_WAIT;
      r_reg.rst_n <= 1'b1;
      r_reg.wait_lim <= BOOT_LAST;
    end else begin
      r_reg <= r_next;
    end
  end

  // Link drive
  assign link.master_reset_n = r_reg.rst_n;
  assign link.input_ref_clock = r_reg.ref_clk;
  assign link.bus_req = r_reg.req;
  assign link.bus_write = r_reg.write;
  assign link.bus_addr = r_reg.addr;
  assign link.bus_wdata = r_reg.wdata;
  // User side
  assign cmd_ready = (r_reg.state == sensor_pkg::H_READY) && !hard_reset_req && !soft_reset_req;
  assign rsp_valid = r_reg.rsp_valid;
  assign rsp_error = r_reg.rsp_error;
  assign rsp_rdata = r_reg.rsp_rdata;
  assign device_ready = r_reg.ready;
  assign pix_valid = r_reg.pix_valid;
  assign pix_word = r_reg.pix_word;
endmodule

// [src/sensor_link_if.sv]
/*
  Board-level link between host and sensor: reset pin, reference
  clock, word-level two-wire bus, parallel port and serial lanes.
  Assumes both ends share clk; pad levels are resolved by the bench.
*/
`timescale 1ns/1ps
interface sensor_link_if;
  // Reset pin and reference clock, host driven
  logic master_reset_n;
  logic input_ref_clock;
  // Two-wire bus transaction, host side
  logic bus_req;
  logic bus_write;
  logic [15:0] bus_addr;
  logic [15:0] bus_wdata;
  // Two-wire bus answer, device side
  logic bus_ack;
  logic bus_nak;
  logic [15:0] bus_rdata;
  logic ctrl_bus_data_oe;
  // Parallel port, one shared enable
  logic [7:0] pixel_data_out;
  logic [1:0] pixel_lsb_out;
  logic pixel_clock_out;
  logic row_active_out;
  logic frame_active_out;
  logic par_oe;
  // Serial lanes: clk_p, clk_n, data_p, data_n
  logic [3:0] lane_out;
  logic lane_oe;
  modport device (
    input master_reset_n, input_ref_clock, bus_req, bus_write, bus_addr, bus_wdata,
    output bus_ack, bus_nak, bus_rdata, ctrl_bus_data_oe,
    output pixel_data_out, pixel_lsb_out, pixel_clock_out, row_active_out,
    output frame_active_out, par_oe, lane_out, lane_oe
  );
  modport host (
    output master_reset_n, input_ref_clock, bus_req, bus_write, bus_addr, bus_wdata,
    input bus_ack, bus_nak, bus_rdata, ctrl_bus_data_oe,
    input pixel_data_out, pixel_lsb_out, pixel_clock_out, row_active_out,
    input frame_active_out, par_oe, lane_out, lane_oe
  );
endinterface

// [src/sensor_pkg.sv]
/*
  Types for the sensor link: state enumerations and the packed
  state records of both ends. Assumes sensor_consts.svh for figures.
*/
package sensor_pkg;
  // Device power/boot states
  typedef enum logic [2:0] {
    DEV_OFF, DEV_POR, DEV_RESET, DEV_BOOT, DEV_STANDBY, DEV_STREAM
  } dev_state_type;
  // Host sequencing states
  typedef enum logic [2:0] {
    H_WAIT, H_BUS, H_READY, H_PRE, H_HARD
  } host_state_type;
  // What a host bus transfer is for
  typedef enum logic [1:0] {
    K_USER, K_POLL, K_SOFT_SET, K_SOFT_CLR
  } bus_kind_type;
  // Device state record
  typedef struct packed {
    dev_state_type state;
    logic [23:0] cnt;
    logic boot_sel;
    logic soft_rst;
    logic standby_req;
    logic [3:0] ref_idle;
    logic ref_prev;
    logic bus_ack;
    logic bus_nak;
    logic bus_oe;
    logic [15:0] bus_rdata;
    logic [11:0] col;
    logic [11:0] row;
    logic [7:0] pix;
    logic [1:0] lsb;
    logic pclk;
    logic row_act;
    logic frame_act;
    logic par_oe;
  } dev_regs_type;
  // Host state record
  typedef struct packed {
    host_state_type state;
    bus_kind_type kind;
    logic [23:0] cnt;
    logic [23:0] wait_lim;
    logic rst_n;
    logic ref_clk;
    logic req;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
    logic rsp_valid;
    logic rsp_error;
    logic [15:0] rsp_rdata;
    logic ready;
    logic pix_valid;
    logic [9:0] pix_word;
  } host_regs_type;
endpackage

// [verif/sensor_link_monitor.sv]
/*
  Checker on the host/sensor link: pin reset, bus answers, blanking
  and pad states. Assumes one clock domain and a bench instance.
*/
`timescale 1ns/1ps
`include "sensor_consts.svh"
module sensor_link_monitor (
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Reset pin, reference clock and bus
  input wire logic master_reset_n,
  input wire logic input_ref_clock,
  input wire logic bus_req,
  input wire logic bus_ack,
  input wire logic ctrl_bus_data_oe,
  // Parallel port and lanes
  input wire logic [7:0] pixel_data_out,
  input wire logic row_active_out,
  input wire logic frame_active_out,
  input wire logic par_oe,
  input wire logic [3:0] lane_out,
  input wire logic lane_oe
);
  // Least pin-low time in system clocks
  localparam int MIN_LOW = `RST_MIN_REF * `REF_DIV;
  // Clocks with pin low, clocks since last reference edge
  logic [15:0] low_cnt_reg;
  logic [7:0] idle_cnt_reg;
  logic ref_prev_reg;
  // Helper counters
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      low_cnt_reg <= 16'h0000;
      idle_cnt_reg <= 8'h00;
      ref_prev_reg <= 1'h0;
    end else begin
      low_cnt_reg <= master_reset_n ? 16'h0000 : low_cnt_reg + 16'h0001;
      ref_prev_reg <= input_ref_clock;
      if (input_ref_clock != ref_prev_reg) begin
        idle_cnt_reg <= 8'h00;
      end else if (idle_cnt_reg != 8'hFF) begin
        idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  // Reference clock still toggling
  sequence ref_running;
    $changed(input_ref_clock) [*8];
  endsequence
  AST_BLANK_ZERO: assert property (
    par_oe && !row_active_out |-> pixel_data_out == `BLANK_DATA)
    else $error("nonzero data during blanking");
  AST_ROW_IN_FRAME: assert property (
    par_oe && row_active_out |-> frame_active_out)
    else $error("row active outside frame");
  AST_RESET_FLOAT: assert property (
    !master_reset_n |-> !par_oe)
    else $error("parallel port driven in reset");
  AST_RESET_MUTE: assert property (
    !master_reset_n |=> !bus_ack)
    else $error("bus answered in reset");
  AST_LANES_LOW: assert property (
    lane_oe |-> lane_out == 4'h0)
    else $error("lanes not low");
  AST_ACK_CAUSE: assert property (
    bus_ack |-> $past(bus_req) && $past(master_reset_n))
    else $error("answer without request");
  AST_ACK_OE: assert property (
    bus_ack |-> ctrl_bus_data_oe ##1 !bus_ack)
    else $error("answer pulse or data enable wrong");
  AST_NO_REF: assert property (
    idle_cnt_reg >= 8'h14 |-> !bus_ack)
    else $error("answer with stopped reference");
  AST_PULSE_WIDTH: assert property (
    $rose(master_reset_n) |-> low_cnt_reg >= MIN_LOW)
    else $error("reset pulse too short");
  AST_REF_GUARD: assert property (
    $fell(master_reset_n) |-> ref_running)
    else $error("reference stopped after reset");
endmodule

// [verif/tb.sv]
/*
  Bench: host and sensor joined by the link; frame, register, reset
  and power scenarios checked against a bench model. Assumes src.
*/
`timescale 1ns/1ps
`include "sensor_consts.svh"
module tb;
  // Short boot and small raster
  localparam int BOOT = 50;
  localparam int COLS = 16;
  localparam int ROWS = 8;
  // Clock, reset, supply and straps
  logic clk, reset_n, power_good, boot_select, par_enable_n;
  // Host user side
  logic hard_reset_req, soft_reset_req, ref_stop, cmd_valid, cmd_write, cmd_ready;
  logic rsp_valid, rsp_error, device_ready, pix_valid, in_reset, booting, streaming, er;
  logic [15:0] cmd_addr, cmd_wdata, rsp_rdata, rd;
  logic [9:0] pix_word;
  // Counters, frame model and random state
  int err_total, samples_checked, n;
  int exp_q[$];
  logic [31:0] rnd;
  sensor_link_if link();
  sensor_device #(.BOOT_CYCLES(BOOT), .ACTIVE_COLS(COLS), .ACTIVE_ROWS(ROWS), .HBLANK(8),
    .VBLANK(4)) sensor_device_i (.clk(clk), .reset_n(reset_n), .link(link),
    .power_good(power_good), .boot_select(boot_select), .par_enable_n(par_enable_n),
    .in_reset(in_reset), .booting(booting), .streaming(streaming));
  sensor_host #(.BOOT_WAIT(BOOT)) sensor_host_i (.clk(clk), .reset_n(reset_n), .link(link),
    .hard_reset_req(hard_reset_req), .soft_reset_req(soft_reset_req), .ref_stop(ref_stop),
    .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_wdata(cmd_wdata),
    .cmd_ready(cmd_ready), .rsp_valid(rsp_valid), .rsp_error(rsp_error), .rsp_rdata(rsp_rdata),
    .device_ready(device_ready), .pix_valid(pix_valid), .pix_word(pix_word));
  sensor_link_monitor monitor_i (.clk(clk), .reset_n(reset_n),
    .master_reset_n(link.master_reset_n), .input_ref_clock(link.input_ref_clock),
    .bus_req(link.bus_req), .bus_ack(link.bus_ack), .ctrl_bus_data_oe(link.ctrl_bus_data_oe),
    .pixel_data_out(link.pixel_data_out), .row_active_out(link.row_active_out),
    .frame_active_out(link.frame_active_out), .par_oe(link.par_oe),
    .lane_out(link.lane_out), .lane_oe(link.lane_oe));
  // 25 MHz clock
  initial begin
    clk = 1'h0;
    forever #20 clk = ~clk;
  end
  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // Verdict and end of run
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  // Signal picked by a waiting loop
  function automatic logic sel(input int w);
    case (w)
      0: return device_ready;
      1: return booting;
      2: return in_reset;
      3: return rsp_valid;
      4: return link.frame_active_out;
      default: return cmd_ready;
    endcase
  endfunction
  // Bounded wait at falling edges; running out ends the run
  task automatic wait_for(input int w, input logic v, input int bound);
    repeat (bound) begin
      if (sel(w) === v) return;
      @(negedge clk);
    end
    err_total++;
    $display("mismatch at %0t: wait ran out", $time);
    finish_test();
  endtask
  // One user register transfer; answer left in rd and er
  task automatic do_cmd(input logic w, input logic [15:0] a, input logic [15:0] d);
    cmd_write = w;
    cmd_addr = a;
    cmd_wdata = d;
    cmd_valid = 1'h1;
    wait_for(5, 1'h1, 300);
    @(negedge clk);
    cmd_valid = 1'h0;
    wait_for(3, 1'h1, 300);
    rd = rsp_rdata;
    er = rsp_error;
  endtask
  // Main sequence, inputs change at falling edges
  initial begin
    {reset_n, hard_reset_req, soft_reset_req, ref_stop, cmd_valid, cmd_write} = 6'h00;
    {power_good, boot_select, par_enable_n} = 3'h6;
    cmd_addr = 16'h0000;
    cmd_wdata = 16'h0000;
    err_total = 0;
    samples_checked = 0;
    rnd = 32'h0000003B;
    repeat (5) @(negedge clk);
    reset_n = 1'h1;
    // Power-on without a pin pulse, strap high
    wait_for(0, 1'h1, 3000);
    check(streaming, 1'h1);
    // One raster against the model
    for (int r = 0; r < ROWS; r++) begin
      for (int c = 0; c < COLS; c++) begin
        exp_q.push_back((r + c) * 4 + c % 4);
      end
    end
    wait_for(4, 1'h0, 400);
    wait_for(4, 1'h1, 400);
    n = 0;
    repeat (288) begin
      if (link.row_active_out === 1'h1) n++;
      @(negedge clk);
      if (pix_valid === 1'h1 && exp_q.size() > 0) check(pix_word, exp_q.pop_front());
    end
    check(n, COLS * ROWS);
    check(exp_q.size(), 0);
    // Standby entry, then random unmapped traffic
    do_cmd(1'h1, `STATE_ADDR, 16'h0001);
    do_cmd(1'h0, `CMD_ADDR, 16'h0000);
    check({er, rd[`BOOT_BUSY_BIT], streaming, link.par_oe, link.lane_out}, 32'h0);
    check(link.pixel_clock_out, 1'h0);
    repeat (3) begin
      rnd = xorshift(rnd);
      do_cmd(1'h1, {8'h01, rnd[7:0]}, rnd[31:16]);
      do_cmd(1'h0, {8'h01, rnd[7:0]}, 16'h0000);
      check({er, rd}, 32'h0);
    end
    do_cmd(1'h0, `STATE_ADDR, 16'h0000);
    check({er, rd}, 32'h1);
    do_cmd(1'h1, `STATE_ADDR, 16'h0000);
    // Stopped reference: request goes unanswered
    ref_stop = 1'h1;
    repeat (20) @(negedge clk);
    do_cmd(1'h0, `CMD_ADDR, 16'h0000);
    check(er, 1'h1);
    ref_stop = 1'h0;
    repeat (20) @(negedge clk);
    // Hard then soft reset from standby, same end state expected
    for (int k = 0; k < 2; k++) begin
      do_cmd(1'h1, `STATE_ADDR, 16'h0001);
      par_enable_n = (k == 0);
      hard_reset_req = (k == 0);
      soft_reset_req = (k == 1);
      @(negedge clk);
      {hard_reset_req, soft_reset_req} = 2'h0;
      wait_for(2, 1'h1, 400);
      if (k == 0) begin
        repeat (40) @(negedge clk);
        check({in_reset, link.master_reset_n, link.par_oe}, 32'h4);
      end
      wait_for(1, 1'h1, 600);
      n = 0;
      while (booting === 1'h1 && n < 200) begin
        n++;
        if (link.par_oe === 1'h1 && k == 0) check(link.par_oe, 1'h0);
        @(negedge clk);
      end
      check(n, BOOT);
      par_enable_n = 1'h0;
      wait_for(0, 1'h1, 2000);
      check({booting, in_reset}, 32'h0);
      do_cmd(1'h0, `STATE_ADDR, 16'h0000);
      check({er, rd, streaming}, 32'h1);
    end
    // Power off, then power-on with strap low
    power_good = 1'h0;
    boot_select = 1'h0;
    @(negedge clk);
    check({link.par_oe, link.lane_oe}, 32'h0);
    repeat (3) @(negedge clk);
    power_good = 1'h1;
    wait_for(1, 1'h1, 300);
    // Boot refuses all but the status read
    do_cmd(1'h0, `STATE_ADDR, 16'h0000);
    check(er, 1'h1);
    do_cmd(1'h0, `CMD_ADDR, 16'h0000);
    check({er, rd[`BOOT_BUSY_BIT]}, 32'h1);
    wait_for(1, 1'h0, 300);
    @(negedge clk);
    check({streaming, link.lane_oe, link.lane_out}, 32'h10);
    finish_test();
  end
endmodule
